// >>> core/codec_link_reset_sleep_clock.sv
// reset and clock sequencer for a standby-powered codec on the link
`timescale 1ns/1ps
`include "codec_rst_map.svh"
module codec_link_reset_sleep_clock
   import codec_rst_pkg::*;
#(
   parameter int LOSS_CYC = `CRS_BCLK_LOSS_CYC,
   parameter int BCLK_HALF = `CRS_BCLK_HALF_CYC,
   parameter int SLEEP_HALF = `CRS_SLEEP_HALF_CYC
) (
   input wire logic clk_sys_i, // standby system clock
   input wire logic rst_b_i, // standby power-on reset, low
   input wire logic link_rst_b_i, // link reset pin, low
   input wire logic link_sync_i, // link frame sync pin
   input wire logic bit_clk_i, // link bit clock pin level
   input wire logic sleep_i, // system in S3/S4/S5 indicator pin
   input wire logic primary_i, // strap: 1 = primary codec
   input wire logic pr4_req_i, // pulse: enter PR4
   input wire logic reg_reset_cmd_i, // pulse: register reset command
   input wire logic wake_evt_i, // pulse: wake event seen
   input wire logic wake_clr_i, // pulse: clear wake event
   output logic core_rst_o, // full core reset level
   output logic warm_o, // pulse: warm reset done
   output logic reinit_o, // pulse: register reinit
   output logic resume_o, // pulse: resume reset seen
   output logic pr4_o, // link in PR4
   output logic wake_o, // wake event pending
   output logic bit_clk_o, // bit clock drive
   output logic bit_clk_oe_b_o, // bit clock enable, low drives
   output logic sleep_clk_o, // local free-running clock
   output logic sel_local_o // 1 = core on local clock
);
   // counts must fit the 8 bit counters
   if (LOSS_CYC < 1 || LOSS_CYC > 255 || BCLK_HALF < 1 || BCLK_HALF > 255 ||
       SLEEP_HALF < 1 || SLEEP_HALF > 255) begin : g_bad_count
      $error("codec_link_reset_sleep_clock: count parameter out of range");
   end

   localparam logic [`CRS_CNT_W-1:0] LOSS_N = `CRS_CNT_W'(LOSS_CYC);
   localparam logic [`CRS_CNT_W-1:0] BH_N = `CRS_CNT_W'(BCLK_HALF - 1);
   localparam logic [`CRS_CNT_W-1:0] SH_N = `CRS_CNT_W'(SLEEP_HALF - 1);

   // pins synchronised: 0 reset, 1 sync, 2 bit clock, 3 sleep, 4 strap
   pin_sync_if #(.W(5)) pins();
   assign pins.raw = {primary_i, sleep_i, bit_clk_i, link_sync_i, link_rst_b_i};

   // link reset idles high, so its synced level starts high
   pin_sync #(.W(5), .IDLE(`CRS_PIN_IDLE)) u_sync (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .s(pins)
   );

   logic rst_lvl, rst_rise, sync_rise, bclk_edge, slp, prim;
   assign rst_lvl = pins.lvl[0];
   assign rst_rise = pins.rise[0];
   assign sync_rise = pins.rise[1];
   assign bclk_edge = pins.rise[2] | pins.fall[2];
   assign slp = pins.lvl[3];
   assign prim = pins.lvl[4];

   link_state_t state_reg, state_next;
   logic core_rst_reg, core_rst_next;
   logic warm_reg, warm_next;
   logic reinit_reg, reinit_next;
   logic resume_reg, resume_next;
   logic wake_reg, wake_next;
   logic resumed_reg, resumed_next;

   // link state, reset kinds and wake state
   always_comb begin
      state_next = state_reg;
      core_rst_next = 1'b0;
      warm_next = 1'b0;
      reinit_next = 1'b0;
      resume_next = 1'b0;
      resumed_next = resumed_reg;
      wake_next = wake_reg;
      if (wake_clr_i) begin
         wake_next = 1'b0;
      end
      if (wake_evt_i) begin
         wake_next = 1'b1; // set wins over clear
      end
      unique case (state_reg)
         ST_RUN: begin
            if (!rst_lvl && slp) begin
               state_next = ST_SLEEP; // reset held during sleep
            end else if (!rst_lvl) begin
               core_rst_next = 1'b1;
            end else if (pr4_req_i) begin
               state_next = ST_PR4;
            end else if (reg_reset_cmd_i) begin
               reinit_next = 1'b1;
            end
         end
         ST_PR4: begin
            if (!rst_lvl) begin
               state_next = slp ? ST_SLEEP : ST_RUN;
               core_rst_next = !slp;
            end else if (sync_rise) begin
               state_next = ST_RUN;
               warm_next = 1'b1;
            end
         end
         ST_SLEEP: begin
            resumed_next = 1'b0;
            if (rst_rise) begin
               state_next = ST_RESUME;
               resume_next = 1'b1;
            end
         end
         ST_RESUME: begin
            resumed_next = 1'b1; // wake state untouched here
            state_next = ST_RUN;
         end
      endcase
      if (core_rst_next) begin
         wake_next = `CRS_WAKE_RST;
         resumed_next = 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         state_reg <= ST_RUN;
         core_rst_reg <= 1'b1;
         warm_reg <= 1'b0;
         reinit_reg <= 1'b0;
         resume_reg <= 1'b0;
         wake_reg <= `CRS_WAKE_RST;
         resumed_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         core_rst_reg <= core_rst_next;
         warm_reg <= warm_next;
         reinit_reg <= reinit_next;
         resume_reg <= resume_next;
         wake_reg <= wake_next;
         resumed_reg <= resumed_next;
      end
   end

   logic [`CRS_CNT_W-1:0] loss_reg, loss_next;
   logic sel_reg, sel_next;
   logic [`CRS_CNT_W-1:0] bdiv_reg, bdiv_next;
   logic bclk_reg, bclk_next;
   logic [`CRS_CNT_W-1:0] sdiv_reg, sdiv_next;
   logic sclk_reg, sclk_next;
   logic drive;

   // primary drives the link clock only while running
   assign drive = prim && (state_reg == ST_RUN) && !core_rst_reg;

   // clock loss watch, clock select and both dividers
   always_comb begin
      loss_next = loss_reg;
      if (bclk_edge) begin
         loss_next = '0;
      end else if (loss_reg != LOSS_N) begin
         loss_next = loss_reg + `CRS_CNT_W'(1);
      end
      sel_next = sel_reg;
      if (loss_next == LOSS_N) begin
         sel_next = 1'b1;
      end else if (resumed_reg && state_reg != ST_SLEEP) begin
         sel_next = 1'b0;
      end
      bdiv_next = bdiv_reg;
      bclk_next = bclk_reg;
      if (!drive) begin
         bdiv_next = '0;
         bclk_next = 1'b0;
      end else if (bdiv_reg == BH_N) begin
         bdiv_next = '0;
         bclk_next = !bclk_reg;
      end else begin
         bdiv_next = bdiv_reg + `CRS_CNT_W'(1);
      end
      sdiv_next = sdiv_reg;
      sclk_next = sclk_reg;
      if (sdiv_reg == SH_N) begin
         sdiv_next = '0;
         sclk_next = !sclk_reg;
      end else begin
         sdiv_next = sdiv_reg + `CRS_CNT_W'(1);
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         loss_reg <= '0;
         sel_reg <= `CRS_SEL_LOCAL_RST;
         bdiv_reg <= '0;
         bclk_reg <= 1'b0;
         sdiv_reg <= '0;
         sclk_reg <= 1'b0;
      end else begin
         loss_reg <= loss_next;
         sel_reg <= sel_next;
         bdiv_reg <= bdiv_next;
         bclk_reg <= bclk_next;
         sdiv_reg <= sdiv_next;
         sclk_reg <= sclk_next;
      end
   end

   // outputs straight from flops, pr4_o and bit_clk_oe_b_o decoded from them
   assign core_rst_o = core_rst_reg;
   assign warm_o = warm_reg;
   assign reinit_o = reinit_reg;
   assign resume_o = resume_reg;
   assign pr4_o = (state_reg == ST_PR4);
   assign wake_o = wake_reg;
   assign bit_clk_o = bclk_reg;
   assign bit_clk_oe_b_o = !drive;
   assign sleep_clk_o = sclk_reg;
   assign sel_local_o = sel_reg;

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);

   property p_cold;
      (state_reg == ST_RUN && !rst_lvl && !slp) |=> core_rst_o ##1 !wake_o;
   endproperty
   a_cold: assert property (p_cold) else $error("cold reset not applied");

   property p_warm;
      (state_reg == ST_PR4 && rst_lvl && sync_rise) |=> warm_o && !pr4_o && !core_rst_o;
   endproperty
   a_warm: assert property (p_warm) else $error("warm reset mishandled");

   property p_reinit;
      (state_reg == ST_RUN && rst_lvl && !pr4_req_i && reg_reset_cmd_i) |=> reinit_o;
   endproperty
   a_reinit: assert property (p_reinit) else $error("register reset lost");

   property p_resume;
      (state_reg == ST_SLEEP && rst_rise) |=> resume_o ##1 (state_reg == ST_RUN);
   endproperty
   a_resume: assert property (p_resume) else $error("resume edge missed");

   property p_keep;
      (state_reg == ST_SLEEP && rst_rise && wake_o && !wake_clr_i) |=> wake_o && !core_rst_o;
   endproperty
   a_keep: assert property (p_keep) else $error("wake state lost on resume");

   property p_prim;
      (prim && state_reg == ST_RUN && !core_rst_o) |-> !bit_clk_oe_b_o ##[1:BCLK_HALF] ($changed(bit_clk_o) || !drive);
   endproperty
   a_prim: assert property (p_prim) else $error("primary not driving bit clock");

   property p_pr4;
      (pr4_o && $past(pr4_o)) |-> bit_clk_oe_b_o && !bit_clk_o;
   endproperty
   a_pr4: assert property (p_pr4) else $error("bit clock runs in PR4");

   property p_loss;
      (!bclk_edge && loss_reg == LOSS_N - `CRS_CNT_W'(1)) |=> sel_local_o;
   endproperty
   a_loss: assert property (p_loss) else $error("no switch to local clock");

   property p_back;
      (bclk_edge && resumed_reg && state_reg == ST_RUN) |=> !sel_local_o;
   endproperty
   a_back: assert property (p_back) else $error("no return to bit clock");
endmodule

// >>> core/pin_sync.sv
// two-flop synchroniser with edge detection
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] IDLE = '0 // idle pin levels, loaded in reset
) (
   input wire logic clk_sys_i, // system clock
   input wire logic rst_b_i, // sync reset, active low
   pin_sync_if.syn s // raw in, level and edges out
);
   logic [W-1:0] meta_reg, meta_next;
   logic [W-1:0] lvl_reg, lvl_next;
   logic [W-1:0] old_reg, old_next;

   // only the second and third stages are looked at
   always_comb begin
      meta_next = s.raw;
      lvl_next = meta_reg;
      old_next = lvl_reg;
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         // idle level avoids a false edge just after reset
         meta_reg <= IDLE;
         lvl_reg <= IDLE;
         old_reg <= IDLE;
      end else begin
         meta_reg <= meta_next;
         lvl_reg <= lvl_next;
         old_reg <= old_next;
      end
   end

   // edges from the settled level
   assign s.lvl = lvl_reg;
   assign s.rise = lvl_reg & ~old_reg;
   assign s.fall = ~lvl_reg & old_reg;
endmodule

// >>> shared/codec_rst_map.svh
// constants for the codec link reset and sleep clock block
`ifndef CODEC_RST_MAP_SVH
`define CODEC_RST_MAP_SVH
`define CRS_CLK_NS 20
`define CRS_BCLK_LOSS_NS 1000
`define CRS_BCLK_LOSS_CYC (`CRS_BCLK_LOSS_NS / `CRS_CLK_NS)
`define CRS_BCLK_HALF_CYC 2
`define CRS_SLEEP_HALF_CYC 16
`define CRS_CNT_W 8
`define CRS_WAKE_RST 1'b0
`define CRS_SEL_LOCAL_RST 1'b1
`define CRS_PIN_IDLE 5'h01
`endif

// >>> shared/codec_rst_pkg.sv
// types for the codec link reset and sleep clock block
package codec_rst_pkg;
   // gray along run -> pr4 -> sleep -> resume
   typedef enum logic [1:0] {
      ST_RUN = 2'h0,
      ST_PR4 = 2'h1,
      ST_SLEEP = 2'h3,
      ST_RESUME = 2'h2
   } link_state_t;
endpackage

// >>> shared/pin_sync_if.sv
// carrier between the pin synchroniser and the sequencer
`timescale 1ns/1ps
interface pin_sync_if #(parameter int W = 1);
   logic [W-1:0] raw;
   logic [W-1:0] lvl;
   logic [W-1:0] rise;
   logic [W-1:0] fall;
   modport src (output raw, input lvl, input rise, input fall);
   modport syn (input raw, output lvl, output rise, output fall);
endinterface

// >>> verif/codec_link_reset_sleep_clock_bench.sv
// self-checking bench for the codec link reset and sleep clock block
`timescale 1ns/1ps
module codec_link_reset_sleep_clock_bench;
   logic clk_sys_i, rst_b_i, primary_i, pr4_req_i, reg_reset_cmd_i, wake_evt_i, wake_clr_i;
   logic run, rst_lvl, sync_lvl, sleep_lvl, m_bclk, link_rst_b, link_sync, sleep_w, bit_clk_w;
   logic core_rst_o, warm_o, reinit_o, resume_o, pr4_o, wake_o;
   logic bit_clk_o, bit_clk_oe_b_o, sleep_clk_o, sel_local_o;
   int n_fail = 0;
   int samples_checked = 0;
   // bit clock wire: the codec drives it when its enable is low
   assign bit_clk_w = (bit_clk_oe_b_o === 1'b0) ? bit_clk_o : m_bclk;
   link_ctrl_model ctrl (.run_i(run), .rst_lvl_i(rst_lvl), .sync_lvl_i(sync_lvl), .sleep_lvl_i(sleep_lvl),
      .bit_clk_o(m_bclk), .link_rst_b_o(link_rst_b), .link_sync_o(link_sync), .sleep_o(sleep_w));
   codec_link_reset_sleep_clock uut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .link_rst_b_i(link_rst_b),
      .link_sync_i(link_sync), .bit_clk_i(bit_clk_w), .sleep_i(sleep_w), .primary_i(primary_i),
      .pr4_req_i(pr4_req_i), .reg_reset_cmd_i(reg_reset_cmd_i), .wake_evt_i(wake_evt_i),
      .wake_clr_i(wake_clr_i), .core_rst_o(core_rst_o), .warm_o(warm_o), .reinit_o(reinit_o),
      .resume_o(resume_o), .pr4_o(pr4_o), .wake_o(wake_o), .bit_clk_o(bit_clk_o),
      .bit_clk_oe_b_o(bit_clk_oe_b_o), .sleep_clk_o(sleep_clk_o), .sel_local_o(sel_local_o));
   // 50 MHz system clock
   initial begin
      clk_sys_i = 1'b0;
      forever #10 clk_sys_i = ~clk_sys_i;
   end
   // advance n edges, landing just after the edge
   task automatic step(input int n);
      repeat (n) begin
         @(posedge clk_sys_i);
         #2;
      end
   endtask
   task automatic chk(input string what, input logic exp, input logic got);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // software command, single then back to back
   task automatic t_reg_reset();
      reg_reset_cmd_i = 1'b1;
      step(1);
      chk("reinit single", 1'b1, reinit_o);
      step(1);
      chk("reinit back to back", 1'b1, reinit_o);
      reg_reset_cmd_i = 1'b0;
      step(1);
      chk("reinit ends", 1'b0, reinit_o);
      chk("no core reset on command", 1'b0, core_rst_o);
   endtask
   // primary sources the clock, stops it in PR4, sync leaves PR4
   task automatic t_primary_pr4();
      int i;
      int cnt;
      logic prev;
      cnt = 0;
      primary_i = 1'b1;
      step(6);
      chk("primary drives pin", 1'b0, bit_clk_oe_b_o);
      for (i = 0; i < 16; i++) begin
         prev = bit_clk_o;
         step(1);
         if (bit_clk_o !== prev) cnt++;
      end
      chk("bit clock 80 ns", 1'b1, cnt == 8);
      pr4_req_i = 1'b1;
      step(1);
      pr4_req_i = 1'b0;
      chk("pr4 entered", 1'b1, pr4_o);
      chk("pin released in pr4", 1'b1, bit_clk_oe_b_o);
      step(2);
      chk("bit clock stopped", 1'b0, bit_clk_o);
      reg_reset_cmd_i = 1'b1;
      step(1);
      reg_reset_cmd_i = 1'b0;
      chk("command refused in pr4", 1'b0, reinit_o);
      sync_lvl = 1'b1;
      for (i = 0; i < 8 && warm_o !== 1'b1; i++) step(1);
      chk("warm pulse", 1'b1, warm_o);
      chk("pr4 left", 1'b0, pr4_o);
      chk("no init on warm", 1'b0, core_rst_o);
      step(1);
      sync_lvl = 1'b0;
      chk("warm one cycle", 1'b0, warm_o);
      primary_i = 1'b0;
      step(6);
      chk("secondary leaves pin", 1'b1, bit_clk_oe_b_o);
   endtask
   // sleep with stopped clock, then resume keeps the wake state
   task automatic t_resume();
      int i;
      int cnt;
      logic prev;
      cnt = 0;
      wake_evt_i = 1'b1;
      step(1);
      wake_evt_i = 1'b0;
      chk("wake set", 1'b1, wake_o);
      sleep_lvl = 1'b1;
      run = 1'b0;
      step(4);
      rst_lvl = 1'b0;
      step(70);
      chk("local clock chosen", 1'b1, sel_local_o);
      chk("no cold reset asleep", 1'b0, core_rst_o);
      for (i = 0; i < 64; i++) begin
         prev = sleep_clk_o;
         step(1);
         if (sleep_clk_o !== prev) cnt++;
      end
      chk("sleep clock 640 ns", 1'b1, cnt == 4);
      rst_lvl = 1'b1;
      for (i = 0; i < 8 && resume_o !== 1'b1; i++) step(1);
      chk("resume pulse", 1'b1, resume_o);
      chk("wake kept", 1'b1, wake_o);
      step(1);
      chk("resume one cycle", 1'b0, resume_o);
      sleep_lvl = 1'b0;
      run = 1'b1;
      for (i = 0; i < 40 && sel_local_o !== 1'b0; i++) step(1);
      chk("back on bit clock", 1'b0, sel_local_o);
   endtask
   // link reset while awake is a cold reset and clears the wake state
   task automatic t_cold();
      int i;
      wake_clr_i = 1'b1;
      step(1);
      wake_clr_i = 1'b0;
      chk("wake cleared", 1'b0, wake_o);
      wake_evt_i = 1'b1;
      wake_clr_i = 1'b1;
      step(1);
      wake_evt_i = 1'b0;
      wake_clr_i = 1'b0;
      chk("wake set wins over clear", 1'b1, wake_o);
      rst_lvl = 1'b0;
      for (i = 0; i < 6 && core_rst_o !== 1'b1; i++) step(1);
      chk("cold core reset", 1'b1, core_rst_o);
      chk("cold clears wake", 1'b0, wake_o);
      rst_lvl = 1'b1;
      for (i = 0; i < 6 && core_rst_o !== 1'b0; i++) step(1);
      chk("cold reset ends", 1'b0, core_rst_o);
   endtask
   // main sequence
   initial begin
      rst_b_i = 1'b0;
      primary_i = 1'b0;
      pr4_req_i = 1'b0;
      reg_reset_cmd_i = 1'b0;
      wake_evt_i = 1'b0;
      wake_clr_i = 1'b0;
      run = 1'b1;
      rst_lvl = 1'b1;
      sync_lvl = 1'b0;
      sleep_lvl = 1'b0;
      step(5);
      chk("core reset at power-on", 1'b1, core_rst_o);
      rst_b_i = 1'b1;
      step(40);
      chk("core reset released", 1'b0, core_rst_o);
      chk("runs on bit clock", 1'b0, sel_local_o);
      t_reg_reset();
      t_primary_pr4();
      t_resume();
      t_cold();
      wrap_up();
   end
   // watchdog for a hang
   initial begin
      #400000;
      n_fail++;
      wrap_up();
   end
endmodule

// >>> verif/link_ctrl_model.sv
// controller-side model: link reset, sync, sleep flag and secondary bit clock
`timescale 1ns/1ps
module link_ctrl_model (
   input wire logic run_i, // bit clock running
   input wire logic rst_lvl_i, // wanted reset level
   input wire logic sync_lvl_i, // wanted sync level
   input wire logic sleep_lvl_i, // system sleeping
   output logic bit_clk_o, // bit clock to codecs
   output logic link_rst_b_o, // link reset, low active
   output logic link_sync_o, // frame sync
   output logic sleep_o // sleep indicator
);
   // reset held at a firm level in every state, never floating
   assign link_rst_b_o = rst_lvl_i;
   assign link_sync_o = sync_lvl_i;
   assign sleep_o = sleep_lvl_i;
   // 160 ns bit clock, held low while stopped, phase apart from the system clock
   initial begin
      bit_clk_o = 1'b0;
      #7;
      forever begin
         if (run_i) begin
            #80 bit_clk_o = ~bit_clk_o;
         end else begin
            bit_clk_o = 1'b0;
            @(posedge run_i);
         end
      end
   end
endmodule
